/* rtl/trig_pkg.sv */
package trig_pkg;

  // Channel limits
  localparam int unsigned CH_MAX       = 40;
  localparam int unsigned CH_DEFAULT   = 40;

  // Register byte offsets
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_CAP_LO   = 8'h08;
  localparam logic [7:0]  ADDR_CAP_HI   = 8'h0c;
  localparam logic [7:0]  ADDR_PAT_BASE = 8'h40;
  localparam logic [7:0]  ADDR_PAT_END  = 8'ha0;
  localparam int unsigned PAT_STRIDE_SH = 5;
  localparam int unsigned PAT_COUNT     = 3;

  // Control fields
  localparam int unsigned CTRL_ARM_BIT    = 0;
  localparam int unsigned CTRL_CANCEL_BIT = 1;
  localparam int unsigned CTRL_DEPTH_LSB  = 2;
  localparam int unsigned CTRL_MODE_LSB   = 4;

  // Status fields
  localparam int unsigned STAT_ARMED_BIT = 0;
  localparam int unsigned STAT_TRIG_BIT  = 1;
  localparam int unsigned STAT_FULL_BIT  = 2;
  localparam int unsigned STAT_COUNT_LSB = 8;

  // Pattern word layout: one nibble per channel, condition in low three bits
  localparam int unsigned CH_PER_WORD = 8;
  localparam int unsigned NIBBLE      = 4;
  localparam int unsigned COND_W      = 3;

  // Reset values and limits
  localparam logic [1:0]  DEPTH_RESET  = 2'h1;
  localparam logic [7:0]  RECORD_LIMIT = 8'h80;

  typedef enum logic [2:0] {
    COND_ANY  = 3'h0,
    COND_RISE = 3'h1,
    COND_FALL = 3'h2,
    COND_LOW  = 3'h3,
    COND_HIGH = 3'h4
  } cond_t;

  typedef enum logic [1:0] {
    MODE_SINGLE    = 2'h0,
    MODE_IMMEDIATE = 2'h1,
    MODE_REPEAT    = 2'h2
  } mode_t;

endpackage

/* rtl/match_if.sv */
`timescale 1ns/1ps
interface match_if #(parameter int unsigned CH = 40);
  logic [CH-1:0]   cur;
  logic [CH-1:0]   prev;
  logic [3*CH-1:0] cond;
  logic            hit;

  modport matcher (input cur, input prev, input cond, output hit);
  modport user    (output cur, output prev, output cond, input hit);
endinterface

/* rtl/toggle_sync.sv */
`timescale 1ns/1ps
module toggle_sync (
  // Destination clock and reset
  input  wire logic dst_clk_i,
  input  wire logic dst_rst_n_i,
  // Source toggle and destination pulse
  input  wire logic src_toggle_i,
  output logic      pulse_o
);

  logic meta;
  logic stable;
  logic last;

  // Two stages, then an edge detect on the stable copy only
  always_ff @(posedge dst_clk_i or negedge dst_rst_n_i)
  begin
    if (!dst_rst_n_i)
    begin
      meta   <= 1'b0;
      stable <= 1'b0;
      last   <= 1'b0;
    end
    else
    begin
      meta   <= src_toggle_i;
      stable <= meta;
      last   <= stable;
    end
  end

  assign pulse_o = stable ^ last;

endmodule

/* rtl/cond_match.sv */
`timescale 1ns/1ps
module cond_match #(parameter int unsigned CH = 40) (
  // Samples, conditions and result
  match_if.matcher m
);

  wire [CH-1:0] ch_ok;

  // One condition check per channel
  genvar c;
  generate
    for (c = 0; c < CH; c++)
    begin : g_ch
      wire [2:0] code = m.cond[3*c +: 3];
      wire       rise = m.cur[c] & ~m.prev[c];
      wire       fall = ~m.cur[c] & m.prev[c];
      assign ch_ok[c] = (code == trig_pkg::COND_ANY) |
                        ((code == trig_pkg::COND_RISE) & rise) |
                        ((code == trig_pkg::COND_FALL) & fall) |
                        ((code == trig_pkg::COND_LOW) & ~m.cur[c]) |
                        ((code == trig_pkg::COND_HIGH) & m.cur[c]);
    end
  endgenerate

  // Unknown codes never match
  assign m.hit = &ch_ok;

endmodule

/* rtl/trigger_capture.sv */
// Behaviour
// [RULE_01] Channel count is a build parameter, one to forty.
// [RULE_02] Each channel condition: any, rising, falling, low or high.
// [RULE_03] Depth one: first pattern match alone triggers.
// [RULE_04] Depth two: first match, then second pattern on a later cycle.
// [RULE_05] Depth three: patterns one, two, three must match in order.
// [RULE_06] Single mode: one arm captures exactly one record.
// [RULE_07] Immediate mode: all patterns don't care, trigger right after arming.
// [RULE_08] Repetitive mode: host re-arms after each capture, same conditions.
// [RULE_09] Arm order: load config, arm, poll trigger, read captured record.
// [RULE_10] Cancel abandons the pending arm and resets the capture logic.
// [RULE_11] Host stops repetitive capture at 128 records.
// [RULE_12] Edges found by comparing each sample with the previous cycle's.
`timescale 1ns/1ps
module trigger_capture #(
  parameter int unsigned CH = trig_pkg::CH_DEFAULT // RULE_01
) (
  // System clock and reset
  input  wire logic          ref_clk_i,
  input  wire logic          reset_n_i,
  // Wishbone slave
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  // Monitored design
  input  wire logic          trig_clk_i,
  input  wire logic [CH-1:0] trig_ch_i,
  // Status levels
  output logic               armed_o,
  output logic               triggered_o
);

  localparam int unsigned PAT_WORDS = (CH + trig_pkg::CH_PER_WORD - 1) / trig_pkg::CH_PER_WORD;
  localparam int unsigned SLOTS     = trig_pkg::PAT_COUNT * PAT_WORDS;
  localparam int unsigned SLOT_W    = $clog2(SLOTS + 1);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT1,
    ST_WAIT2,
    ST_WAIT3
  } stage_t;

  // System-side state
  logic [1:0]      depth;
  logic [1:0]      mode;
  logic            armed;
  logic            triggered;
  logic [7:0]      rec_count;
  logic            arm_tgl;
  logic            cancel_tgl;
  logic [31:0]     pat_mem [SLOTS];
  logic [CH-1:0]   cap_sys;
  logic            ack;
  logic [31:0]     rdata;

  // Link-side state
  logic [1:0]      link_rst_q;
  logic [CH-1:0]   prev_ch;
  logic [CH-1:0]   cap_link;
  logic [1:0]      depth_l;
  logic            imm_l;
  logic [3*CH-1:0] cond_l [trig_pkg::PAT_COUNT];
  logic            trig_tgl;
  stage_t          stage;
  stage_t          next_stage;
  logic            fire;

  // Bus decode
  wire             req       = wb_cyc_i & wb_stb_i;
  wire             wr_take   = req & wb_we_i & ack;
  wire             rd_load   = req & ~ack;
  wire             is_ctrl   = wb_adr_i == trig_pkg::ADDR_CTRL;
  wire             is_status = wb_adr_i == trig_pkg::ADDR_STATUS;
  wire             is_cap_lo = wb_adr_i == trig_pkg::ADDR_CAP_LO;
  wire             is_cap_hi = wb_adr_i == trig_pkg::ADDR_CAP_HI;
  wire [7:0]       pat_off   = wb_adr_i - trig_pkg::ADDR_PAT_BASE;
  wire [1:0]       pat_idx   = pat_off[trig_pkg::PAT_STRIDE_SH +: 2];
  wire [2:0]       word_idx  = pat_off[4:2];
  wire             is_pat    = (wb_adr_i >= trig_pkg::ADDR_PAT_BASE) & (wb_adr_i < trig_pkg::ADDR_PAT_END) &
                               (32'(word_idx) < PAT_WORDS) & (wb_adr_i[1:0] == 2'h0);
  wire [SLOT_W-1:0] slot     = SLOT_W'(32'(pat_idx) * PAT_WORDS + 32'(word_idx));
  wire [31:0]      lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Control strobes, taken only on the edge the master sees ack
  wire             ctrl_wr    = wr_take & is_ctrl & wb_sel_i[0];
  wire             arm_req    = ctrl_wr & wb_dat_i[trig_pkg::CTRL_ARM_BIT];
  wire             cancel_req = ctrl_wr & wb_dat_i[trig_pkg::CTRL_CANCEL_BIT];
  wire [1:0]       wr_depth   = wb_dat_i[trig_pkg::CTRL_DEPTH_LSB +: 2];
  wire [1:0]       next_depth = (wr_depth == 2'h0) ? trig_pkg::DEPTH_RESET : wr_depth;
  wire             trig_pulse;
  wire             rec_full   = rec_count == trig_pkg::RECORD_LIMIT;

  // Readback words
  wire [31:0]      ctrl_word   = {26'h0, mode, depth, 2'h0};
  wire [31:0]      status_word = {16'h0, rec_count, 5'h0, rec_full, triggered, armed};
  wire [63:0]      cap_wide    = 64'(cap_sys);
  wire [31:0]      pat_word    = is_pat ? pat_mem[slot] : 32'h0;
  wire [31:0]      read_mux    = is_ctrl   ? ctrl_word :
                                 is_status ? status_word :
                                 is_cap_lo ? cap_wide[31:0] :
                                 is_cap_hi ? cap_wide[63:32] :
                                 pat_word;

  // Bus answer: ack one cycle after the request, data registered with it
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ack   <= 1'b0;
      rdata <= 32'h0;
    end
    else
    begin
      ack <= rd_load;
      if (rd_load)
        rdata <= wb_we_i ? 32'h0 : read_mux;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rdata;

  // Pattern storage, byte lanes honoured
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int i = 0; i < SLOTS; i++)
        pat_mem[i] <= 32'h0;
    end
    else if (wr_take & is_pat)
    begin
      pat_mem[slot] <= (pat_mem[slot] & ~lane_mask) | (wb_dat_i & lane_mask); // RULE_02
    end
  end

  // Control fields and arm/cancel events toward the link
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      depth      <= trig_pkg::DEPTH_RESET;
      mode       <= trig_pkg::MODE_SINGLE;
      arm_tgl    <= 1'b0;
      cancel_tgl <= 1'b0;
    end
    else
    begin
      if (ctrl_wr)
      begin
        depth <= next_depth;
        mode  <= wb_dat_i[trig_pkg::CTRL_MODE_LSB +: 2];
      end
      arm_tgl    <= arm_tgl ^ arm_req;       // RULE_09
      cancel_tgl <= cancel_tgl ^ cancel_req; // RULE_10
    end
  end

  // Status: a trigger in the same cycle as a clear still lands
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      armed     <= 1'b0;
      triggered <= 1'b0;
      rec_count <= 8'h0;
      cap_sys   <= '0;
    end
    else
    begin
      armed     <= arm_req | (armed & ~trig_pulse & ~cancel_req); // RULE_06
      triggered <= trig_pulse | (triggered & ~arm_req & ~cancel_req); // RULE_09
      if (cancel_req)
        rec_count <= trig_pulse ? 8'h1 : 8'h0; // RULE_10
      else if (trig_pulse & ~rec_full)
        rec_count <= rec_count + 8'h1; // RULE_08
      if (trig_pulse)
        cap_sys <= cap_link; // Held still since the edge that flipped the toggle
    end
  end

  assign armed_o     = armed;
  assign triggered_o = triggered;

  // Trigger event back from the link domain
  toggle_sync u_trig_sync (
    .dst_clk_i    (ref_clk_i),
    .dst_rst_n_i  (reset_n_i),
    .src_toggle_i (trig_tgl),
    .pulse_o      (trig_pulse)
  );

  // Link reset: asserts at once, releases on the link clock
  always_ff @(posedge trig_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      link_rst_q <= 2'h0;
    else
      link_rst_q <= {link_rst_q[0], 1'b1};
  end

  wire link_rst_n = link_rst_q[1];
  wire arm_l;
  wire cancel_l;

  toggle_sync u_arm_sync (
    .dst_clk_i    (trig_clk_i),
    .dst_rst_n_i  (link_rst_n),
    .src_toggle_i (arm_tgl),
    .pulse_o      (arm_l)
  );

  toggle_sync u_cancel_sync (
    .dst_clk_i    (trig_clk_i),
    .dst_rst_n_i  (link_rst_n),
    .src_toggle_i (cancel_tgl),
    .pulse_o      (cancel_l)
  );

  // Pattern fields, one nibble per channel
  wire [3*CH-1:0] pat_cond [trig_pkg::PAT_COUNT];
  wire [2:0]      hit;

  genvar p;
  genvar c;
  generate
    for (p = 0; p < trig_pkg::PAT_COUNT; p++)
    begin : g_pat
      for (c = 0; c < CH; c++)
      begin : g_field
        assign pat_cond[p][3*c +: 3] =
          pat_mem[p*PAT_WORDS + c/trig_pkg::CH_PER_WORD][trig_pkg::NIBBLE*(c%trig_pkg::CH_PER_WORD) +: 3];
      end

      match_if #(.CH(CH)) mif ();

      // Immediate mode overrides every pattern to don't care
      assign mif.cur  = trig_ch_i;
      assign mif.prev = prev_ch;
      assign mif.cond = imm_l ? '0 : cond_l[p]; // RULE_07
      assign hit[p]   = mif.hit;

      cond_match #(.CH(CH)) u_match (
        .m (mif)
      );
    end
  endgenerate

  // Previous sample and config copy; config is static while the arm toggle is in flight
  always_ff @(posedge trig_clk_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      prev_ch <= '0;
      depth_l <= trig_pkg::DEPTH_RESET;
      imm_l   <= 1'b0;
      for (int i = 0; i < trig_pkg::PAT_COUNT; i++)
        cond_l[i] <= '0;
    end
    else
    begin
      prev_ch <= trig_ch_i; // RULE_12
      if (arm_l)
      begin
        depth_l <= depth;
        imm_l   <= mode == trig_pkg::MODE_IMMEDIATE;
        for (int i = 0; i < trig_pkg::PAT_COUNT; i++)
          cond_l[i] <= pat_cond[i];
      end
    end
  end

  // Sequence walk; each stage only looks from the cycle after it is entered
  always_comb
  begin
    next_stage = stage;
    fire       = 1'b0;
    unique case (stage)
      ST_IDLE:
        next_stage = ST_IDLE;
      ST_WAIT1:
        if (hit[0])
        begin
          if (depth_l == 2'h1)
          begin
            fire       = 1'b1; // RULE_03
            next_stage = ST_IDLE;
          end
          else
            next_stage = ST_WAIT2;
        end
      ST_WAIT2:
        if (hit[1])
        begin
          if (depth_l == 2'h2)
          begin
            fire       = 1'b1; // RULE_04
            next_stage = ST_IDLE;
          end
          else
            next_stage = ST_WAIT3;
        end
      ST_WAIT3:
        if (hit[2])
        begin
          fire       = 1'b1; // RULE_05
          next_stage = ST_IDLE;
        end
    endcase
    if (cancel_l)
    begin
      fire       = 1'b0;
      next_stage = ST_IDLE; // RULE_10
    end
    else if (arm_l)
    begin
      fire       = 1'b0;
      next_stage = ST_WAIT1;
    end
  end

  // One record per arm, then idle until the next arm
  always_ff @(posedge trig_clk_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      stage    <= ST_IDLE;
      trig_tgl <= 1'b0;
      cap_link <= '0;
    end
    else
    begin
      stage <= next_stage; // RULE_06
      if (fire)
      begin
        trig_tgl <= ~trig_tgl;
        cap_link <= trig_ch_i;
      end
    end
  end

endmodule

/* testbench/trig_capture_assertions.sv */
`timescale 1ns/1ps
module trig_capture_assertions #(parameter int unsigned CH = 40) (
  // Clock and reset
  input wire logic        ref_clk_i,
  input wire logic        reset_n_i,
  // Bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Status levels
  input wire logic        armed_o,
  input wire logic        triggered_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Request decode
  wire req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire ctrl_wr = req && wb_we_i && wb_adr_i == trig_pkg::ADDR_CTRL && wb_sel_i[0];
  wire stat_rd = req && !wb_we_i && wb_adr_i == trig_pkg::ADDR_STATUS;

  ack_latency_a :
    assert property (req |=> wb_ack_o) else $error("no ack after request");
  ack_pulse_a :
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_cause_a :
    assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  write_data_zero_a :
    assert property (wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0) else $error("write returned data");
  status_mirror_a :
    assert property ($past(stat_rd) |-> wb_dat_o[1:0] == $past({triggered_o, armed_o}))
    else $error("status bits differ from levels");
  trig_excl_a :
    assert property (triggered_o |-> !armed_o) else $error("armed while triggered");
  trig_needs_arm_a :
    assert property ($rose(triggered_o) |-> $past(armed_o)) else $error("trigger without arm");
  cancel_clears_a :
    assert property (ctrl_wr && wb_dat_i[1] |-> ##[1:20] !armed_o) else $error("cancel left core armed");
  arm_takes_a :
    assert property (ctrl_wr && wb_dat_i[0] && !wb_dat_i[1] |-> ##[1:30] (armed_o || triggered_o))
    else $error("arm not taken");

  // Main scenarios
  cover property ($rose(triggered_o));
  cover property (ctrl_wr && wb_dat_i[1]);
  cover property (stat_rd ##2 stat_rd);
endmodule

bind trigger_capture trig_capture_assertions #(.CH(CH)) u_chk (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .armed_o(armed_o), .triggered_o(triggered_o));

/* testbench/trig_host.sv */
`timescale 1ns/1ps
module trig_host #(parameter int unsigned NW = 1) (
  // Clock and bus answer
  input  wire logic        ref_clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] rdat_i,
  // Bus request
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      wdat_o
);
  initial {cyc_o, stb_o, we_o, adr_o, sel_o, wdat_o} = '0;

  // Classic cycle; everything held until ack is sampled
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q);
    @(posedge ref_clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, wdat_o} <= {2'b11, w, a, s, d};
    do @(posedge ref_clk_i); while (ack_i !== 1'b1);
    q = rdat_i;
    {cyc_o, stb_o} <= 2'b00;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, 4'hf, q);
  endtask

  // Partial write, only the byte lanes set in s
  task automatic wr_lanes(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    xfer(1'b1, a, d, s, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, 4'hf, q);
  endtask

  // Immediate arming wants every pattern don't care
  task automatic load_any();
    for (int k = 0; k < 3; k++)
      for (int w = 0; w < NW; w++)
        wr(trig_pkg::ADDR_PAT_BASE + 8'(k << trig_pkg::PAT_STRIDE_SH) + 8'(w * 4), 32'h0);
  endtask

  // Polling is already over; the core is reset and depth one, single mode written
  task automatic cancel();
    wr(trig_pkg::ADDR_CTRL, 32'h6);
  endtask

  // Same conditions re-armed after each record, stopping at the limit
  task automatic repeat_run(input logic [31:0] ctrl, output int n);
    logic [31:0] q;
    logic [7:0]  old;
    n = 0;
    do
    begin
      rd(trig_pkg::ADDR_STATUS, q);
      old = q[15:8];
      wr(trig_pkg::ADDR_CTRL, ctrl);
      do rd(trig_pkg::ADDR_STATUS, q); while (q[15:8] == old);
      n++;
    end
    while (q[15:8] < trig_pkg::RECORD_LIMIT);
  endtask
endmodule

/* testbench/tb_trigger_capture.sv */
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin num_errors++; \
  $display("FAIL %s expected %h seen %h", n, e, s); end end
module tb_trigger_capture;
  localparam int unsigned CH = 8;
  logic          ref_clk_i = 1'b0;
  logic          trig_clk_i = 1'b0;
  logic          reset_n_i = 1'b0;
  logic [CH-1:0] trig_ch = '0;
  wire           cyc, stb, we, ack, armed, trig;
  wire  [7:0]    adr;
  wire  [3:0]    sel;
  wire  [31:0]   wdat, rdat;
  int            num_errors = 0;
  int            n_checks = 0;
  int            cnt = 0;
  int            n;
  logic [31:0]   rng = 32'h0000ca4c;
  logic [31:0]   q;
  logic [31:0]   w;

  // Clocks unrelated in phase
  initial forever #25 ref_clk_i = ~ref_clk_i;
  initial
  begin
    #13;
    forever #32 trig_clk_i = ~trig_clk_i;
  end

  trigger_capture #(.CH(CH)) DUT (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .trig_clk_i(trig_clk_i), .trig_ch_i(trig_ch), .armed_o(armed), .triggered_o(trig));
  trig_host #(.NW(1)) host (
    .ref_clk_i(ref_clk_i), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .wdat_o(wdat));

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // Reference match of one pattern against current and previous sample
  function automatic bit hit(logic [31:0] p, logic [CH-1:0] c, logic [CH-1:0] o);
    hit = 1;
    for (int i = 0; i < CH; i++)
      case (p[4*i+:3])
        3'h0: ;
        3'h1: hit &= c[i] & !o[i];
        3'h2: hit &= !c[i] & o[i];
        3'h3: hit &= !c[i];
        3'h4: hit &= c[i];
        default: hit = 0;
      endcase
  endfunction

  task automatic check_status(input logic a, input logic t);
    host.rd(trig_pkg::ADDR_STATUS, q);
    `CHK("status", {8'(cnt), 5'h0, cnt == 128, t, a}, q[15:0])
    `CHK("armed_o", a, armed)
    `CHK("triggered_o", t, trig)
  endtask

  // One arm: load, arm, stream, poll, read back; mode 3 is a never-match single arm
  task automatic run(input int d, input int m);
    logic [31:0]   p [3];
    logic [CH-1:0] s [$];
    logic [CH-1:0] o;
    int            st;
    int            idx;
    logic          fired;
    o = '0;
    st = 0;
    idx = -1;
    trig_ch <= '0;
    // First pattern only rise or high, so the quiet lead-in cannot match
    for (int k = 0; k < 3; k++)
      p[k] = 32'(k ? xs() % 4 + 1 : 1 + 3 * (xs() % 2)) << (4 * (xs() % CH));
    if (m == 3)
      p[0] = 32'h5;
    if (m == 1)
      host.load_any();
    else
      for (int k = 0; k < 3; k++)
        host.wr(trig_pkg::ADDR_PAT_BASE + 8'(k << trig_pkg::PAT_STRIDE_SH), p[k]);
    for (int i = 0; i < 34; i++)
      s.push_back(i < 30 ? CH'(xs()) : s[29]);
    for (int i = 0; i < 34 && idx < 0; i++)
    begin
      if (hit(p[st], s[i], o) && st == d - 1)
        idx = i;
      else if (hit(p[st], s[i], o))
        st++;
      o = s[i];
    end
    fired = m == 1 || idx >= 0;
    host.wr(trig_pkg::ADDR_CTRL, 32'(d << 2 | (m % 3) << 4 | 1));
    repeat (6) @(posedge trig_clk_i);
    if (m != 1)
      foreach (s[i])
      begin
        @(posedge trig_clk_i);
        trig_ch <= s[i];
      end
    repeat (4) @(posedge trig_clk_i);
    repeat (8) @(posedge ref_clk_i);
    if (fired)
      cnt = cnt < 128 ? cnt + 1 : 128;
    check_status(!fired, fired);
    if (fired)
    begin
      host.rd(trig_pkg::ADDR_CAP_LO, q);
      `CHK("cap_lo", 32'(m == 1 ? '0 : s[idx]), q)
      host.rd(trig_pkg::ADDR_CAP_HI, q);
      `CHK("cap_hi", 32'h0, q)
    end
    else
    begin
      host.cancel();
      cnt = 0;
      check_status(1'b0, 1'b0);
    end
    $display("test depth %0d mode %0d done", d, m);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge trig_clk_i);
    // Reset values, depth zero stored as one, unmapped hole
    check_status(1'b0, 1'b0);
    host.rd(trig_pkg::ADDR_CTRL, q);
    `CHK("ctrl", 32'h4, q)
    host.wr(trig_pkg::ADDR_CTRL, 32'h0);
    host.rd(trig_pkg::ADDR_CTRL, q);
    `CHK("ctrl", 32'h4, q)
    host.rd(8'h10, q);
    `CHK("hole", 32'h0, q)
    // Control write without lane 0 must not arm or change fields
    host.wr_lanes(trig_pkg::ADDR_CTRL, 32'h0000002d, 4'he);
    host.rd(trig_pkg::ADDR_CTRL, q);
    `CHK("ctrl_lanes", 32'h4, q)
    for (int k = 0; k < 3; k++)
    begin
      w = xs();
      host.wr(trig_pkg::ADDR_PAT_BASE + 8'(k << trig_pkg::PAT_STRIDE_SH), w);
      host.rd(trig_pkg::ADDR_PAT_BASE + 8'(k << trig_pkg::PAT_STRIDE_SH), q);
      `CHK("pattern", w, q)
    end
    // Only lane 1 of the last pattern word may change
    host.wr_lanes(trig_pkg::ADDR_PAT_BASE + 8'(2 << trig_pkg::PAT_STRIDE_SH), ~w, 4'h2);
    host.rd(trig_pkg::ADDR_PAT_BASE + 8'(2 << trig_pkg::PAT_STRIDE_SH), q);
    `CHK("pattern_lanes", {w[31:16], ~w[15:8], w[7:0]}, q)
    $display("test registers done");
    // Every depth under every mode, then an abandoned arm
    for (int i = 0; i < 9; i++)
      run(i % 3 + 1, i / 3);
    run(2, 3);
    host.load_any();
    host.repeat_run(32'h00000025, n);
    cnt = 128;
    `CHK("records", 128, n)
    check_status(1'b0, 1'b1);
    $display("test repetitive done");
    tally_and_finish();
  end

  // Hang guard
  initial
  begin
    repeat (60000) @(posedge ref_clk_i);
    num_errors++;
    $display("FAIL watchdog expected done seen hang");
    tally_and_finish();
  end
endmodule
